// *** logic/flash_front.v ***
// Serial front end, write latch, region protection and status word of a serial flash.
`timescale 1ns/1ps
`include "flash_front_map.vh"
//
// Behaviour
// RULE_01 - Works with clock mode 0 or 3.
// RULE_02 - Sample on rising edge, shift on falling.
// RULE_03 - Dual read commands use lanes 0 and 1.
// RULE_04 - Pause entry waits for serial clock low.
// RULE_05 - Pause exit waits for serial clock low.
// RULE_06 - Paused: float output, ignore clock and data.
// RULE_07 - Pause never stops a running operation.
// RULE_08 - Chip select high resets the interface.
// RULE_09 - Set-latch command sets the write latch.
// RULE_10 - Reset and write commands clear the latch.
// RULE_11 - Protect bits select a read-only region.
// RULE_12 - Block-sized regions, upper or lower placement.
// RULE_13 - Sector-sized regions in top or bottom block.
// RULE_14 - Write-protect low locks protect and lock bits.
// RULE_15 - Deep power-down ignores all but release.
// RULE_16 - Sixteen-bit status word with fixed layout.
// RULE_17 - Busy flag high during program, erase, status write.
// RULE_18 - Program wraps inside its 256-byte page.
// RULE_19 - Sixteen 4K sectors in each 64K block.
// RULE_20 - Write latch clear refuses all modifications.
// RULE_21 - Lock mode selects the protection method.
// RULE_22 - Four-lane enable disables protect and pause pins.
// RULE_23 - Transfer opens with one command byte, MSB first.

module flash_front (
  input wire mclk, // System clock.
  input wire nrst, // Asynchronous reset, active low.
  input wire sclk, // Serial clock pin.
  input wire cs_n, // Chip select pin, active low.
  input wire lane0_in, // Lane 0 pin level.
  output reg lane0_out, // Lane 0 drive value.
  output reg lane0_oe_n, // Lane 0 enable, low drives.
  input wire lane1_in, // Lane 1 pin level.
  output reg lane1_out, // Lane 1 drive value.
  output reg lane1_oe_n, // Lane 1 enable, low drives.
  input wire wp_n, // Write-protect pin, active low.
  input wire pause_n, // Pause pin, active low.
  output reg [20:0] rd_addr, // Array read address.
  input wire [7:0] rd_data, // Array data one cycle after rd_addr.
  output reg prog_valid, // Pulse, one program byte.
  output reg [20:0] prog_addr, // Address of the program byte.
  output reg [7:0] prog_data, // Program byte.
  output reg op_start, // Pulse, operation committed.
  output reg [2:0] op_kind, // Kind of the committed operation.
  output reg [20:0] op_addr, // Address of the committed operation.
  input wire op_done, // Pulse from the core, operation ended.
  output reg [15:0] status_word, // Live copy of the status word.
  output reg deep_sleep // Deep power-down entered.
);

  localparam S_CMD = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_DUMMY = 3'h2;
  localparam S_DIN = 3'h3;
  localparam S_DOUT = 3'h4;
  localparam S_WAIT = 3'h5;

  reg [5:0] s1_r;
  reg [5:0] s2_r;
  reg sclk_d_r;
  reg cs_d_r;
  reg paused_r;
  reg [2:0] st_r;
  reg [7:0] cmd_r;
  reg [7:0] sh_r;
  reg [2:0] bidx_r;
  reg [2:0] nbyte_r;
  reg [20:0] addr_r;
  reg [12:0] page_r;
  reg [7:0] col_r;
  reg wr_ok_r;
  reg [7:0] wlo_r;
  reg [7:0] whi_r;
  reg [7:0] osh_r;
  reg [2:0] obit_r;
  reg dual_r;
  reg drive_r;
  reg wel_r;
  reg busy_r;
  reg [4:0] bp_r;
  reg [1:0] lock_r;
  reg qe_r;

  reg [7:0] sh_nxt;
  reg [2:0] bidx_nxt;
  reg [7:0] out_nxt;

  // ----------------------------------------------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------------------------------------------
  wire sclk_s = s2_r[0];
  wire cs_s = s2_r[1];
  wire l0_s = s2_r[2];
  wire l1_s = s2_r[3];
  // With four lanes enabled the protect and pause pins are data, so read as inactive.
  wire wp_eff = qe_r | s2_r[4]; // [RULE_22]
  wire pause_eff = qe_r | s2_r[5]; // [RULE_22]
  // Only edges seen with select low and no pause count, so mode 3 idle-high is harmless.
  wire rise = ~cs_s & ~paused_r & sclk_s & ~sclk_d_r; // [RULE_01] [RULE_02] [RULE_06]
  wire fall = ~cs_s & ~paused_r & ~sclk_s & sclk_d_r; // [RULE_02] [RULE_06]
  wire cs_rise = cs_s & ~cs_d_r;
  wire two_in = (st_r == S_ADDR) && (cmd_r == `CMD_DUAL_IO); // [RULE_03]
  wire byte_done = rise && (bidx_nxt == 3'h0);
  wire [20:0] addr_nxt = {addr_r[12:0], sh_nxt};
  wire [15:0] status_w = {6'h00, qe_r, lock_r, bp_r, wel_r, busy_r}; // [RULE_16]
  // Lock mode 01 follows the pin, 10 and 11 both lock until the next reset.
  wire st_locked = lock_r[1] | (lock_r[0] & ~wp_eff); // [RULE_14] [RULE_21]

  // Protected-region decode; used for program, sector erase and block erase.
  function prot;
    input [4:0] bp;
    input [20:0] a;
    reg [5:0] cnt;
    reg [5:0] blk;
    reg [4:0] sec;
    begin
      cnt = 6'h01 << (bp[2:0] - 3'h1);
      blk = {1'b0, a[20:16]}; // [RULE_19]
      sec = {1'b0, a[15:12]}; // [RULE_19]
      if (bp[2:0] == 3'h0) begin
        prot = 1'b0;
      end else if (bp[2:1] == 2'h3) begin
        prot = 1'b1;
      end else if (!bp[4]) begin
        prot = bp[3] ? (blk < cnt) : (blk >= (`NUM_BLOCKS - cnt)); // [RULE_11] [RULE_12]
      end else begin
        if (bp[2]) begin
          cnt = 6'h08;
        end
        if (bp[3]) begin
          prot = (blk[4:0] == 5'h00) && (sec < cnt[4:0]); // [RULE_13]
        end else begin
          prot = (blk[4:0] == `BLK_LAST) && (sec >= (`SECT_PER_BLK - cnt[4:0])); // [RULE_13]
        end
      end
    end
  endfunction

  // Two flip-flops on every pin; a third stage on the clock and select gives the previous level.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 6'h3f;
      s2_r <= 6'h3f;
      sclk_d_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      s1_r <= {pause_n, wp_n, lane1_in, lane0_in, cs_n, sclk};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[0];
      cs_d_r <= s2_r[1];
    end
  end

  // ----------------------------------------------------------------------------
  // Pause control
  // ----------------------------------------------------------------------------
  // Entry and exit are both held off while the serial clock is high.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      paused_r <= 1'b0;
    end else if (cs_s) begin
      paused_r <= 1'b0; // [RULE_08]
    end else if (!paused_r && !pause_eff && !sclk_s) begin
      paused_r <= 1'b1; // [RULE_04]
    end else if (paused_r && pause_eff && !sclk_s) begin
      paused_r <= 1'b0; // [RULE_05]
    end
  end

  // ----------------------------------------------------------------------------
  // Shift path
  // ----------------------------------------------------------------------------
  // Next input byte and bit index, one or two bits per rising edge.
  always @* begin
    sh_nxt = two_in ? {sh_r[5:0], l1_s, l0_s} : {sh_r[6:0], l0_s}; // [RULE_03] [RULE_23]
    bidx_nxt = bidx_r + (two_in ? 3'h2 : 3'h1);
    if (obit_r != 3'h0) begin
      out_nxt = osh_r;
    end else if (cmd_r == `CMD_RD_STAT_LO) begin
      out_nxt = status_w[7:0];
    end else if (cmd_r == `CMD_RD_STAT_HI) begin
      out_nxt = status_w[15:8];
    end else begin
      out_nxt = rd_data;
    end
  end

  // ----------------------------------------------------------------------------
  // Command sequencer and status bits
  // ----------------------------------------------------------------------------
  // Busy and the status bits keep running through a pause; only shifting stops.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= S_CMD;
      cmd_r <= `CMD_NONE;
      sh_r <= 8'h00;
      bidx_r <= 3'h0;
      nbyte_r <= 3'h0;
      addr_r <= 21'h000000;
      page_r <= 13'h0000;
      col_r <= 8'h00;
      wr_ok_r <= 1'b0;
      wlo_r <= 8'h00;
      whi_r <= 8'h00;
      osh_r <= 8'h00;
      obit_r <= 3'h0;
      dual_r <= 1'b0;
      drive_r <= 1'b0;
      lane0_out <= 1'b0;
      lane1_out <= 1'b0;
      rd_addr <= 21'h000000;
      prog_valid <= 1'b0;
      prog_addr <= 21'h000000;
      prog_data <= 8'h00;
      op_start <= 1'b0;
      op_kind <= `OP_PROGRAM;
      op_addr <= 21'h000000;
      wel_r <= 1'b0; // [RULE_10]
      busy_r <= 1'b0;
      bp_r <= `BP_RESET;
      lock_r <= `LOCK_RESET;
      qe_r <= 1'b0;
      deep_sleep <= 1'b0;
    end else begin
      prog_valid <= 1'b0;
      op_start <= 1'b0;
      if (op_done) begin
        busy_r <= 1'b0; // [RULE_07] [RULE_17]
      end
      if (cs_s) begin
        st_r <= S_CMD; // [RULE_08]
        bidx_r <= 3'h0;
        nbyte_r <= 3'h0;
        obit_r <= 3'h0;
        dual_r <= 1'b0;
        drive_r <= 1'b0;
        // Modifying commands act only when select rises on a byte boundary.
        if (cs_rise && bidx_r == 3'h0) begin
          cmd_r <= `CMD_NONE;
          case (cmd_r)
            `CMD_SET_WL: begin
              if (nbyte_r == 3'h1) wel_r <= 1'b1; // [RULE_09]
            end
            `CMD_CLR_WL: begin
              if (nbyte_r == 3'h1) wel_r <= 1'b0; // [RULE_10]
            end
            `CMD_WR_STAT: begin
              if ((nbyte_r == 3'h2 || nbyte_r == 3'h3) && wel_r && !st_locked) begin // [RULE_20]
                bp_r <= wlo_r[6:2];
                lock_r[0] <= wlo_r[7];
                if (nbyte_r == 3'h3) begin
                  lock_r[1] <= whi_r[0];
                  qe_r <= whi_r[1];
                end
                wel_r <= 1'b0; // [RULE_10]
                busy_r <= 1'b1; // [RULE_17]
                op_start <= 1'b1;
                op_kind <= `OP_STATUS;
                op_addr <= 21'h000000;
              end
            end
            `CMD_PAGE_WR: begin
              if (nbyte_r >= 3'h5 && wr_ok_r) begin // [RULE_20]
                wel_r <= 1'b0; // [RULE_10]
                busy_r <= 1'b1; // [RULE_17]
                op_start <= 1'b1;
                op_kind <= `OP_PROGRAM;
                op_addr <= {page_r, 8'h00};
              end
            end
            `CMD_SECT_ER: begin
              if (nbyte_r == 3'h4 && wel_r && !prot(bp_r, {addr_r[20:12], 12'h000})) begin
                wel_r <= 1'b0; // [RULE_10] [RULE_11] [RULE_20]
                busy_r <= 1'b1;
                op_start <= 1'b1;
                op_kind <= `OP_SECT_ER;
                op_addr <= {addr_r[20:12], 12'h000}; // [RULE_19]
              end
            end
            `CMD_BLK_ER: begin
              if (nbyte_r == 3'h4 && wel_r && !prot(bp_r, {addr_r[20:16], 16'h0000}) &&
                  !prot(bp_r, {addr_r[20:16], 16'hffff})) begin // [RULE_11] [RULE_20]
                wel_r <= 1'b0; // [RULE_10]
                busy_r <= 1'b1;
                op_start <= 1'b1;
                op_kind <= `OP_BLK_ER;
                op_addr <= {addr_r[20:16], 16'h0000};
              end
            end
            `CMD_FULL_ER, `CMD_FULL_ER_ALT: begin
              if (nbyte_r == 3'h1 && wel_r && bp_r[2:0] == 3'h0) begin // [RULE_11] [RULE_20]
                wel_r <= 1'b0; // [RULE_10]
                busy_r <= 1'b1;
                op_start <= 1'b1;
                op_kind <= `OP_FULL_ER;
                op_addr <= 21'h000000;
              end
            end
            `CMD_SLEEP: begin
              if (nbyte_r == 3'h1) deep_sleep <= 1'b1;
            end
            default: begin
            end
          endcase
        end
        if (cs_rise && cmd_r == `CMD_WAKE) begin
          deep_sleep <= 1'b0;
          cmd_r <= `CMD_NONE;
        end
      end else if (rise) begin
        sh_r <= sh_nxt;
        bidx_r <= bidx_nxt;
        if (byte_done) begin
          if (nbyte_r != 3'h7) nbyte_r <= nbyte_r + 3'h1;
          case (st_r)
            S_CMD: begin
              cmd_r <= sh_nxt; // [RULE_23]
              // Asleep, only release is heard; busy, only status reads.
              if (deep_sleep && sh_nxt != `CMD_WAKE) begin
                cmd_r <= `CMD_NONE; // [RULE_15]
                st_r <= S_WAIT;
              end else if (busy_r && sh_nxt != `CMD_RD_STAT_LO &&
                           sh_nxt != `CMD_RD_STAT_HI) begin
                cmd_r <= `CMD_NONE;
                st_r <= S_WAIT;
              end else begin
                case (sh_nxt)
                  `CMD_RD_STAT_LO, `CMD_RD_STAT_HI: st_r <= S_DOUT;
                  `CMD_READ, `CMD_FAST_READ, `CMD_DUAL_OUT, `CMD_DUAL_IO: st_r <= S_ADDR;
                  `CMD_PAGE_WR, `CMD_SECT_ER, `CMD_BLK_ER: st_r <= S_ADDR;
                  `CMD_WR_STAT: st_r <= S_DIN;
                  default: st_r <= S_WAIT;
                endcase
              end
            end
            S_ADDR: begin
              if (nbyte_r <= 3'h3) addr_r <= addr_nxt;
              if (nbyte_r == 3'h3) begin
                rd_addr <= addr_nxt;
                page_r <= addr_nxt[20:8];
                col_r <= addr_nxt[7:0];
                wr_ok_r <= wel_r && !prot(bp_r, addr_nxt); // [RULE_11] [RULE_20]
                case (cmd_r)
                  `CMD_READ: st_r <= S_DOUT;
                  `CMD_FAST_READ, `CMD_DUAL_OUT: st_r <= S_DUMMY;
                  `CMD_PAGE_WR: st_r <= S_DIN;
                  `CMD_DUAL_IO: st_r <= S_ADDR;
                  default: st_r <= S_WAIT;
                endcase
              end else if (nbyte_r == 3'h4) begin
                st_r <= S_DOUT; // [RULE_03]
                dual_r <= 1'b1;
              end
            end
            S_DUMMY: begin
              st_r <= S_DOUT;
              dual_r <= (cmd_r == `CMD_DUAL_OUT); // [RULE_03]
            end
            S_DIN: begin
              if (cmd_r == `CMD_WR_STAT) begin
                if (nbyte_r == 3'h1) wlo_r <= sh_nxt;
                if (nbyte_r == 3'h2) whi_r <= sh_nxt;
              end else if (wr_ok_r) begin
                prog_valid <= 1'b1;
                prog_data <= sh_nxt;
                prog_addr <= {page_r, col_r};
                col_r <= col_r + 8'h01; // [RULE_18]
              end
            end
            default: begin
            end
          endcase
        end
      end else if (fall && st_r == S_DOUT) begin
        // A new byte is taken on the first falling edge of each byte time.
        drive_r <= 1'b1;
        lane1_out <= out_nxt[7]; // [RULE_02]
        if (dual_r) begin
          lane0_out <= out_nxt[6]; // [RULE_03]
          osh_r <= {out_nxt[5:0], 2'h0};
          obit_r <= obit_r + 3'h2;
        end else begin
          osh_r <= {out_nxt[6:0], 1'b0};
          obit_r <= obit_r + 3'h1;
        end
        if (obit_r == 3'h0 && cmd_r != `CMD_RD_STAT_LO && cmd_r != `CMD_RD_STAT_HI) begin
          rd_addr <= rd_addr + 21'h000001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Output enables and status copy
  // ----------------------------------------------------------------------------
  // Lanes float whenever paused or deselected, one cycle behind the cause.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lane0_oe_n <= 1'b1;
      lane1_oe_n <= 1'b1;
      status_word <= 16'h0000;
    end else begin
      lane1_oe_n <= ~(drive_r & ~paused_r & ~cs_s); // [RULE_06]
      lane0_oe_n <= ~(drive_r & dual_r & ~paused_r & ~cs_s); // [RULE_03] [RULE_06]
      status_word <= status_w; // [RULE_16]
    end
  end

endmodule

// *** logic/flash_front_map.vh ***
// Command codes, status word layout, reset values and array geometry for the flash front end.
`ifndef FLASH_FRONT_MAP_VH
`define FLASH_FRONT_MAP_VH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define CMD_SET_WL 8'h06
`define CMD_CLR_WL 8'h04
`define CMD_RD_STAT_LO 8'h05
`define CMD_RD_STAT_HI 8'h35
`define CMD_WR_STAT 8'h01
`define CMD_READ 8'h03
`define CMD_FAST_READ 8'h0b
`define CMD_DUAL_OUT 8'h3b
`define CMD_DUAL_IO 8'hbb
`define CMD_PAGE_WR 8'h02
`define CMD_SECT_ER 8'h20
`define CMD_BLK_ER 8'hd8
`define CMD_FULL_ER 8'hc7
`define CMD_FULL_ER_ALT 8'h60
`define CMD_SLEEP 8'hb9
`define CMD_WAKE 8'hab
`define CMD_NONE 8'h00

// ----------------------------------------------------------------------------
// Status word layout and reset values
// ----------------------------------------------------------------------------
`define ST_BUSY 0
`define ST_WL 1
`define ST_BP_LO 2
`define ST_LOCK_LO 7
`define ST_QUAD 9
`define BP_RESET 5'h00
`define LOCK_RESET 2'h0

// ----------------------------------------------------------------------------
// Operation kinds handed to the array core
// ----------------------------------------------------------------------------
`define OP_PROGRAM 3'h0
`define OP_SECT_ER 3'h1
`define OP_BLK_ER 3'h2
`define OP_FULL_ER 3'h3
`define OP_STATUS 3'h4

// ----------------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------------
`define NUM_BLOCKS 6'h20
`define SECT_PER_BLK 5'h10
`define BLK_LAST 5'h1f

`endif

// *** tb/flash_front_monitor.sv ***
// Port-level assertions for the flash front end.
`timescale 1ns/1ps
module flash_front_monitor (
  input wire mclk, // System clock.
  input wire nrst, // Reset, active low.
  input wire sclk, // Serial clock pin.
  input wire cs_n, // Chip select pin.
  input wire pause_n, // Pause pin.
  input wire lane0_oe_n, // Lane 0 enable, low drives.
  input wire lane1_out, // Lane 1 drive value.
  input wire lane1_oe_n, // Lane 1 enable, low drives.
  input wire [20:0] rd_addr, // Array read address.
  input wire op_start, // Operation committed.
  input wire op_done, // Operation ended.
  input wire [15:0] status_word, // Status word copy.
  input wire deep_sleep // Deep power-down.
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Pin inputs pass a synchroniser, so conditions must hold a few cycles first.
  sequence s_deselected;
    cs_n [*6];
  endsequence
  sequence s_paused;
    (!pause_n && !cs_n && !sclk && !status_word[9]) [*8];
  endsequence

  property p_idle_float;
    s_deselected |-> lane0_oe_n && lane1_oe_n;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("lane driven while deselected");
  property p_pause_float;
    s_paused |-> lane0_oe_n && lane1_oe_n;
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("lane driven in pause");
  property p_pause_hold;
    s_paused |=> $stable(rd_addr);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("address moved in pause");
  property p_shift_fall;
    !lane1_oe_n && $changed(lane1_out) |-> !$past(sclk, 2);
  endproperty
  a_shift_fall: assert property (p_shift_fall) else $error("output moved off a fall");
  property p_busy_rise;
    op_start |-> ##[1:3] status_word[0];
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy missing after start");
  property p_busy_cause;
    $rose(status_word[0]) |-> $past(op_start) || $past(op_start, 2) || $past(op_start, 3);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_busy_drop;
    op_done && !op_start |-> ##[1:3] !status_word[0];
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy stuck after done");
  property p_latch_commit;
    op_start |-> status_word[1] ##[1:3] !status_word[1];
  endproperty
  a_latch_commit: assert property (p_latch_commit) else $error("latch wrong at commit");
  property p_sleep_quiet;
    deep_sleep |-> !op_start;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("operation in deep sleep");
  property p_reserved;
    status_word[15:10] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits set");
endmodule

bind flash_front flash_front_monitor i_flash_front_monitor (
  .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .pause_n(pause_n),
  .lane0_oe_n(lane0_oe_n), .lane1_out(lane1_out), .lane1_oe_n(lane1_oe_n),
  .rd_addr(rd_addr), .op_start(op_start), .op_done(op_done),
  .status_word(status_word), .deep_sleep(deep_sleep));

// *** tb/spi_host_model.sv ***
// Behavioural host controller that drives the serial link.
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk, // Serial clock, still outside frames.
  output logic cs_n, // Chip select, active low.
  output logic mosi, // Host drive for lane 0.
  output logic pause_n, // Pause request, active low.
  input wire miso // Lane 1 level.
);
  logic idle_hi = 1'b0; // Mode 3 when high.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    pause_n = 1'b1;
  end

  // Pause is released before each new select, so a frame never opens paused.
  task automatic open_frame(input logic m3);
    idle_hi = m3;
    sclk = m3;
    pause_n = 1'b1;
    #200;
    cs_n = 1'b0;
    #200;
  endtask

  // Data changes while the clock is low and is sampled at the rise.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #80;
      sclk = 1'b1;
      rx[i] = miso;
      #80;
    end
  endtask

  // A released lane shows the inverse of its last bit, not a stale copy.
  task automatic close_frame();
    sclk = idle_hi;
    #80;
    cs_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask

  // The clock is parked low before the pause pin moves.
  task automatic hold_link(input logic on);
    sclk = 1'b0;
    #80;
    pause_n = ~on;
    #80;
  endtask
endmodule

// *** tb/serial_flash_interface_protection_test.sv ***
// Self-checking bench for the flash front end against a host model.
`timescale 1ns/1ps
module serial_flash_interface_protection_test;
  typedef struct {logic wp; int nb; logic [31:0] d; logic [15:0] st; logic ds;
    logic [2:0] k; logic [20:0] a;} row_t;
  logic mclk = 1'b0, nrst = 1'b0, wp_n = 1'b1, op_done = 1'b0, flt = 1'b0;
  logic [7:0] rx, ops = 8'h00, ops0;
  logic [4:0] busy_cnt = 5'h00;
  logic [2:0] last_kind;
  logic [20:0] last_addr;
  logic [20:0] last_pa;
  logic [7:0] last_pd, n_prog = 8'h00;
  int fail_count = 0, n_compared = 0;
  wire sclk, cs_n, mosi, pause_n, lane0_in, lane1_in, lane0_out, lane0_oe_n;
  wire lane1_out, lane1_oe_n, prog_valid, op_start, deep_sleep;
  wire [20:0] rd_addr, prog_addr, op_addr;
  wire [7:0] rd_data, prog_data;
  wire [2:0] op_kind;
  wire [15:0] status_word;
  // Write protect, byte count, frame, status, sleep, op kind (7 none), op address.
  row_t rows [23] = '{
    '{1, 1, 32'h06, 16'h0002, 0, 3'h7, 21'h0}, '{1, 1, 32'h04, 16'h0000, 0, 3'h7, 21'h0},
    '{1, 2, 32'h0104, 16'h0000, 0, 3'h7, 21'h0}, '{1, 1, 32'h06, 16'h0002, 0, 3'h7, 21'h0},
    '{1, 2, 32'h0104, 16'h0004, 0, 3'h4, 21'h0}, '{1, 1, 32'h06, 16'h0006, 0, 3'h7, 21'h0},
    '{1, 4, 32'h201f0000, 16'h0006, 0, 3'h7, 21'h0},
    '{1, 4, 32'h201ef000, 16'h0004, 0, 3'h1, 21'h1ef000},
    '{1, 1, 32'h06, 16'h0006, 0, 3'h7, 21'h0}, '{1, 2, 32'h0144, 16'h0044, 0, 3'h4, 21'h0},
    '{1, 1, 32'h06, 16'h0046, 0, 3'h7, 21'h0},
    '{1, 4, 32'h201ff000, 16'h0046, 0, 3'h7, 21'h0},
    '{1, 4, 32'h201fe000, 16'h0044, 0, 3'h1, 21'h1fe000},
    '{1, 1, 32'h06, 16'h0046, 0, 3'h7, 21'h0}, '{1, 2, 32'h0180, 16'h0080, 0, 3'h4, 21'h0},
    '{0, 1, 32'h06, 16'h0082, 0, 3'h7, 21'h0}, '{0, 2, 32'h0100, 16'h0082, 0, 3'h7, 21'h0},
    '{1, 2, 32'h0100, 16'h0000, 0, 3'h4, 21'h0}, '{1, 1, 32'h0b9, 16'h0000, 1, 3'h7, 21'h0},
    '{1, 1, 32'h06, 16'h0000, 1, 3'h7, 21'h0}, '{1, 1, 32'hab, 16'h0000, 0, 3'h7, 21'h0},
    '{1, 1, 32'h06, 16'h0002, 0, 3'h7, 21'h0},
    '{1, 4, 32'hd8012345, 16'h0000, 0, 3'h2, 21'h010000}};

  // Undriven lane 1 toggles each cycle so a stale bit never reads as data; undriven lane 0 follows the host.
  assign lane0_in = lane0_oe_n ? mosi : lane0_out;
  assign lane1_in = lane1_oe_n ? flt : lane1_out;
  assign rd_data = rd_addr[7:0] ^ rd_addr[15:8];

  flash_front i_flash_front (.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .lane0_in(lane0_in), .lane0_out(lane0_out), .lane0_oe_n(lane0_oe_n),
    .lane1_in(lane1_in), .lane1_out(lane1_out), .lane1_oe_n(lane1_oe_n), .wp_n(wp_n),
    .pause_n(pause_n), .rd_addr(rd_addr), .rd_data(rd_data), .prog_valid(prog_valid),
    .prog_addr(prog_addr), .prog_data(prog_data), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done),
    .status_word(status_word), .deep_sleep(deep_sleep));
  spi_host_model i_spi_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .pause_n(pause_n), .miso(lane1_in));

  // Array core stand-in: records each commit and finishes it 20 cycles later.
  always @(posedge mclk) begin
    flt <= ~flt;
    if (prog_valid) begin
      n_prog <= n_prog + 8'h01;
      last_pa <= prog_addr;
      last_pd <= prog_data;
    end
    op_done <= (busy_cnt == 5'h01);
    if (op_start) begin
      ops <= ops + 8'h01;
      last_kind <= op_kind;
      last_addr <= op_addr;
      busy_cnt <= 5'h14;
    end else if (busy_cnt != 5'h00) begin
      busy_cnt <= busy_cnt - 5'h01;
    end
  end

  task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic put(input int nb, input logic [31:0] d);
    for (int i = nb - 1; i >= 0; i--) i_spi_host_model.xfer(d[8*i +: 8], rx);
  endtask

  task automatic send(input int nb, input logic [31:0] d, input logic m3);
    i_spi_host_model.open_frame(m3);
    put(nb, d);
    i_spi_host_model.close_frame();
    for (int w = 0; w < 200 && status_word[0] !== 1'b0; w++) @(negedge mclk);
    @(negedge mclk);
  endtask

  task automatic give_verdict();
    $display("Mismatches %0d of %0d comparisons", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // The whole run needs about 112 us; a hang is cut off well past that.
  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (8) @(negedge mclk);
    chk("reset status", 21'h0, 21'(status_word));
    foreach (rows[r]) begin
      wp_n = rows[r].wp;
      ops0 = ops;
      send(rows[r].nb, rows[r].d, 1'b0);
      chk("status", 21'(rows[r].st), 21'(status_word));
      chk("sleep", 21'(rows[r].ds), 21'(deep_sleep));
      chk("op count", 21'(ops0 + 8'(rows[r].k != 3'h7)), 21'(ops));
      if (rows[r].k != 3'h7) begin
        chk("op kind", 21'(rows[r].k), 21'(last_kind));
        chk("op addr", rows[r].a, last_addr);
      end
    end
    // Status read in mode 3 after setting the latch.
    send(1, 32'h06, 1'b1);
    i_spi_host_model.open_frame(1'b1);
    put(2, 32'h0500);
    chk("serial status", 21'h02, 21'(rx));
    i_spi_host_model.close_frame();
    // Read paused mid-stream; stray clocks in the pause must shift nothing.
    i_spi_host_model.open_frame(1'b0);
    put(4, 32'h03012345);
    put(1, 32'h00);
    chk("read byte", 21'h66, 21'(rx));
    i_spi_host_model.hold_link(1'b1);
    chk("paused enable", 21'h1, 21'(lane1_oe_n));
    put(1, 32'hff);
    i_spi_host_model.hold_link(1'b0);
    put(1, 32'h00);
    chk("resumed byte", 21'h65, 21'(rx));
    i_spi_host_model.close_frame();
    // Dual output: lane 1 carries the upper bit of each pair.
    i_spi_host_model.open_frame(1'b0);
    put(4, 32'h3b0000f0);
    put(2, 32'h0000);
    chk("dual lane0 drive", 21'h0, 21'(lane0_oe_n));
    chk("dual upper bits", 21'hcc, 21'(rx));
    i_spi_host_model.close_frame();
    // Page write over the page end: the second byte wraps to the page start.
    i_spi_host_model.open_frame(1'b0);
    put(4, 32'h020123ff);
    put(2, 32'h5aa5);
    i_spi_host_model.close_frame();
    chk("prog count", 21'h2, 21'(n_prog));
    chk("prog addr", 21'h012300, last_pa);
    chk("prog data", 21'ha5, 21'(last_pd));
    chk("page op kind", 21'h0, 21'(last_kind));
    chk("page op addr", 21'h012300, last_addr);
    chk("page status", 21'h0, 21'(status_word));
    // Reset in mid-run with the latch set: power-up leaves it clear.
    send(1, 32'h06, 1'b0);
    chk("latch before reset", 21'h2, 21'(status_word));
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (8) @(negedge mclk);
    chk("mid reset status", 21'h0, 21'(status_word));
    give_verdict();
  end
endmodule
